// *** dv/sec_checker_bench.sv ***
// Purpose: self-checking bench for the spi error checker
// Assumes: outcome of a frame shows just after the edge that sees select high
// Notes:   echo and signed modes are random per frame
module sec_checker_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, mi, flip, sgn, echo, lock, mclr, sclk, ss_n, mosi, act, err, mism;
    logic [7:0] en;
    sec_pkg::sec_reply_t rep;
    sec_pkg::sec_req_t req;
    logic [32:0] exp_q[$];
    int error_cnt, n_tests;
    sec_spi_master u_mst (.i_ref_clk(clk), .o_sclk(sclk), .o_ss_n(ss_n), .o_mosi(mosi));
    sec_checker dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_sclk(sclk), .i_ss_n(ss_n),
        .i_mosi(mosi), .i_miso_intended(mi), .i_miso_actual(mi ^ flip), .i_signed_data(sgn),
        .i_echo_command(echo), .i_source_enable(en), .i_init_complete_lock(lock),
        .i_mismatch_clear(mclr), .o_err_reply_active(act), .o_err_reply(rep), .o_req(req),
        .o_spi_error(err), .o_third_device_status_mismatch(mism));
    // clock, random intended miso, watchdog
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    always @(negedge clk) mi <= 1'($urandom);
    initial begin
        #300000;
        error_cnt++;
        stop_test();
    end
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = sec_pkg::CRC_SEED;
        for (int i = 23; i >= 0; i--) c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? sec_pkg::CRC_POLY : 8'h00);
        return c;
    endfunction : crc8
    task automatic chk_frame(input logic [32:0] e, input logic [32:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] frame exp %h got %h", e, g);
        end
    endtask : chk_frame
    task automatic chk_flag(input logic e);
        n_tests++;
        if (mism !== e) begin
            error_cnt++;
            $display("[ERR] mismatch flag exp %h got %h", e, mism);
        end
    endtask : chk_flag
    // flt = {mismatch, sclk high at rise, sclk high at fall, crc corrupt}
    task automatic frm(input logic [3:0] c, input logic [2:0] s, input logic [7:0] a, input int n,
                       input logic [3:0] flt, input logic [2:0] go, input logic er);
        logic [31:0] f;
        logic bad;
        f = {c, s, 1'($urandom), a, 16'($urandom)};
        f[7:0] = crc8(f[31:8]) ^ {7'h00, flt[0]};
        echo = 1'($urandom);
        sgn = 1'($urandom);
        bad = er | flt[3];
        exp_q.push_back({er, go, a, bad, (bad && echo && n == 32) ? c : 4'h0,
            (bad && c[3] && n == 32 && sgn) ? 12'h800 : 12'h000, bad ? 4'hf : 4'h0});
        flip = flt[3];
        u_mst.xfer(f, n, flt[2:1]);
        flip = 1'h0;
    endtask : frm
    // monitor: compare each frame outcome with the oldest note
    initial begin : mon
        logic ss_q;
        logic [32:0] e;
        logic [32:0] g;
        ss_q = 1'h1;
        forever begin
            @(posedge clk);
            if (ss_n === 1'h1 && ss_q === 1'h0) begin
                #1;
                g = {err, req, act, rep};
                e = exp_q.pop_front();
                if (e[31:29] == 3'h0) g[28:21] = e[28:21];
                chk_frame(e, g);
            end
            ss_q = ss_n;
        end
    end
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    // main sequence
    initial begin
        {rst_n, flip, sgn, echo, lock, mclr, mi} = 7'h00;
        en = 8'hff;
        error_cnt = 0;
        n_tests = 0;
        void'($urandom(32'he35b9696));
        repeat (16) @(negedge clk);
        rst_n = 1'h1;
        repeat (2) @(negedge clk);
        en = (8'($urandom) | 8'h08) & 8'hdf;
        frm(4'h0, 3'h0, 8'($urandom), 32, 4'h0, 3'h2, 1'h0);
        frm(4'h1, 3'h0, 8'h33, 32, 4'h0, 3'h1, 1'h0);
        for (int c = 2; c < 8; c++) frm(4'(c), 3'h0, 8'h21, 32, 4'h0, 3'h0, 1'h0);
        for (int c = 8; c < 16; c++) frm(4'(c), 3'h3, 8'h07, 32, 4'h0, 3'h4, 1'h0);
        for (int c = 8; c < 16; c++) frm(4'(c), 3'h5, 8'h07, 32, 4'h0, 3'h0, 1'h1);
        frm(4'h9, 3'h3, 8'h00, 32, 4'h1, 3'h0, 1'h1);
        frm(4'h0, 3'h3, 8'h42, 32, 4'h1, 3'h0, 1'h1);
        lock = 1'h1;
        frm(4'h1, 3'h0, 8'h13, 32, 4'h0, 3'h0, 1'h1);
        frm(4'h1, 3'h0, 8'h14, 32, 4'h0, 3'h1, 1'h0);
        frm(4'h0, 3'h0, 8'h13, 32, 4'h0, 3'h2, 1'h0);
        lock = 1'h0;
        frm(4'h0, 3'h0, 8'h00, 0, 4'h0, 3'h0, 1'h0);
        frm(4'h0, 3'h0, 8'h00, 31, 4'h0, 3'h0, 1'h1);
        frm(4'h0, 3'h0, 8'h00, 33, 4'h0, 3'h0, 1'h1);
        frm(4'h0, 3'h0, 8'h00, 32, 4'h2, 3'h0, 1'h1);
        frm(4'h0, 3'h0, 8'h00, 32, 4'h4, 3'h0, 1'h1);
        chk_flag(1'h0);
        frm(4'h1, 3'h0, 8'h55, 32, 4'h8, 3'h1, 1'h0);
        chk_flag(1'h1);
        frm(4'h0, 3'h0, 8'h56, 32, 4'h8, 3'h0, 1'h0);
        frm(4'h8, 3'h3, 8'h00, 32, 4'h8, 3'h0, 1'h0);
        mclr = 1'h1;
        @(negedge clk);
        mclr = 1'h0;
        @(negedge clk);
        chk_flag(1'h0);
        frm(4'h0, 3'h0, 8'h60, 32, 4'h0, 3'h2, 1'h0);
        repeat (4) @(negedge clk);
        stop_test();
    end
endmodule : sec_checker_bench

// *** dv/sec_err_checker.sv ***
// Purpose: temporal checks on the spi error checker ports
// Assumes: sclk levels and select edges last two or more ref cycles
// Notes:   bound to every sec_checker instance
module sec_err_checker #(
    parameter int unsigned SRC_COUNT = 8
) (
    // clock, reset and pins
    input wire logic                 i_ref_clk,
    input wire logic                 i_reset_n,
    input wire logic                 i_sclk,
    input wire logic                 i_ss_n,
    input wire logic                 i_mosi,
    input wire logic                 i_miso_intended,
    input wire logic                 i_miso_actual,
    // configuration
    input wire logic                 i_signed_data,
    input wire logic                 i_echo_command,
    input wire logic [SRC_COUNT-1:0] i_source_enable,
    input wire logic                 i_init_complete_lock,
    input wire logic                 i_mismatch_clear,
    // outputs under watch
    input wire logic                 o_err_reply_active,
    input wire sec_pkg::sec_reply_t  o_err_reply,
    input wire sec_pkg::sec_req_t    o_req,
    input wire logic                 o_spi_error,
    input wire logic                 o_third_device_status_mismatch
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] cnt_reg;
    logic       sclk_reg;
    logic       ss_reg;
    logic       mark_reg;
    // rising edges and output mismatches of the current frame
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_reg <= 6'h00;
            sclk_reg <= 1'h0;
            ss_reg <= 1'h1;
            mark_reg <= 1'h0;
        end else begin
            sclk_reg <= i_sclk;
            ss_reg <= i_ss_n;
            if (i_ss_n) cnt_reg <= 6'h00;
            else if (i_sclk && !sclk_reg) cnt_reg <= cnt_reg + 6'h01;
            if (!i_ss_n && ss_reg) mark_reg <= 1'h0;
            else if (!i_ss_n && i_sclk && !sclk_reg && i_miso_actual != i_miso_intended)
                mark_reg <= 1'h1;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_end;
        $rose(i_ss_n);
    endsequence
    sequence s_bad_cnt;
        s_end ##0 (cnt_reg != 6'h00 && cnt_reg != 6'h20);
    endsequence
    AST_SCLK_AT_RISE: assert property (s_end ##0 i_sclk |-> ##[1:2] o_spi_error)
        else $error("sclk high at select rise without spi error");
    AST_EDGE_COUNT: assert property (s_bad_cnt |-> ##[1:2] o_spi_error)
        else $error("bad edge count without spi error");
    AST_ERR_STATUS: assert property (o_spi_error |-> o_err_reply_active
        && o_err_reply.status_field == sec_pkg::STATUS_SPI_ERR) else $error("wrong error status");
    AST_ERR_PULSE: assert property (o_spi_error |-> !o_req.sensor_go && !o_req.read_go
        && !o_req.write_go ##1 !o_spi_error) else $error("error pulse wrong");
    AST_IDLE_REPLY: assert property (!o_err_reply_active |-> o_err_reply == 20'h00000)
        else $error("inactive reply not zero");
    AST_SENSOR_CODE: assert property (o_err_reply.sensor_value_field != 12'h000
        |-> o_err_reply.sensor_value_field == 12'h800) else $error("bad sensor error code");
    AST_MIS_SET: assert property (!i_ss_n && $rose(i_sclk)
        && i_miso_actual != i_miso_intended |=> o_third_device_status_mismatch)
        else $error("mismatch flag not set");
    AST_MIS_HOLD: assert property (o_third_device_status_mismatch && !i_mismatch_clear
        |=> o_third_device_status_mismatch) else $error("mismatch flag lost");
    AST_MIS_DROP: assert property (o_req.sensor_go || o_req.read_go |-> !mark_reg)
        else $error("request issued in mismatch frame");
    AST_MIS_REPLY: assert property (s_end ##0 (mark_reg && cnt_reg == 6'h20) |-> ##[1:2]
        o_err_reply_active) else $error("no error reply after mismatch frame");
endmodule : sec_err_checker

bind sec_checker sec_err_checker #(.SRC_COUNT(SRC_COUNT)) u_err_chk (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_ss_n(i_ss_n),
    .i_mosi(i_mosi), .i_miso_intended(i_miso_intended), .i_miso_actual(i_miso_actual),
    .i_signed_data(i_signed_data), .i_echo_command(i_echo_command),
    .i_source_enable(i_source_enable), .i_init_complete_lock(i_init_complete_lock),
    .i_mismatch_clear(i_mismatch_clear), .o_err_reply_active(o_err_reply_active),
    .o_err_reply(o_err_reply), .o_req(o_req), .o_spi_error(o_spi_error),
    .o_third_device_status_mismatch(o_third_device_status_mismatch));

// *** dv/sec_spi_master.sv ***
// Purpose: spi master model driving frames into the device
// Assumes: each sclk level held two ref cycles, msb first
// Notes:   sclk stands low and mosi inverts between frames
module sec_spi_master (
    // reference clock
    input  wire logic i_ref_clk,
    // spi pins toward the device
    output logic      o_sclk,
    output logic      o_ss_n,
    output logic      o_mosi
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels
    initial begin
        o_sclk = 1'h0;
        o_ss_n = 1'h1;
        o_mosi = 1'h0;
    end
    // one frame of n rising edges; bk raises sclk at select fall or rise
    task automatic xfer(input logic [31:0] f, input int n, input logic [1:0] bk);
        @(negedge i_ref_clk);
        o_sclk = bk[0];
        @(negedge i_ref_clk);
        o_ss_n = 1'h0;
        repeat (2) @(negedge i_ref_clk);
        o_sclk = 1'h0;
        for (int i = 0; i < n; i++) begin
            o_mosi = f[31 - (i % 32)];
            repeat (2) @(negedge i_ref_clk);
            o_sclk = 1'h1;
            repeat (2) @(negedge i_ref_clk);
            o_sclk = 1'h0;
        end
        repeat (2) @(negedge i_ref_clk);
        o_sclk = bk[1];
        repeat (2) @(negedge i_ref_clk);
        o_ss_n = 1'h1;
        o_mosi = ~o_mosi;
        repeat (2) @(negedge i_ref_clk);
        o_sclk = 1'h0;
        repeat (4) @(negedge i_ref_clk);
    endtask : xfer
endmodule : sec_spi_master

// *** hdl/sec_checker.sv ***
// Purpose: framing, crc, source, lock and output-compare checks on the
//          spi slave port, and the error reply fields for the next frame
// Assumes: serial clock, select and data inputs are synchronous to i_ref_clk
//          and slow enough to be seen as levels for several clock cycles
// Notes:   all outputs are registered; request strobes last one cycle;
//          a cut frame is never echoed and carries no sensor error code;
//          reply fields read all zero while no error reply is active

// Function
// RULE1: error reply command bits are zero or an echo of received command
// RULE2: unsigned sensor reply puts error code 0x000 in sensor field
// RULE3: signed sensor reply puts error code 0x800 in sensor field
// RULE4: replies to non-sensor commands drive the sensor field to zero
// RULE5: serial clock high at a select edge is an spi error
// RULE6: rising edge count other than zero or thirty-two is an spi error
// RULE7: command crc failure on the input line is an spi error
// RULE8: sensor request for a source without enable is an spi error
// RULE9: with init lock set, writes except lock register are spi errors
// RULE10: any spi error gives the error reply with spi error status
// RULE11: each driven output bit is compared; a mismatch sets the sticky flag
// RULE12: valid sensor request in a mismatch frame is dropped, error reply next
// RULE13: valid write in a mismatch frame still happens, error reply next
// RULE14: valid read in a mismatch frame is not done, error reply next
// RULE15: error reply is given in the frame right after the offending one
module sec_checker #(
    parameter int unsigned   SRC_COUNT = 8,
    parameter logic [7:0]    CRC_POLY  = sec_pkg::CRC_POLY,
    parameter logic [7:0]    CRC_SEED  = sec_pkg::CRC_SEED
) (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_reset_n,
    // spi pins as seen by the device
    input  wire logic                  i_sclk,
    input  wire logic                  i_ss_n,
    input  wire logic                  i_mosi,
    // output compare: intended bit and level read back from the pin
    input  wire logic                  i_miso_intended,
    input  wire logic                  i_miso_actual,
    // configuration
    input  wire logic                  i_signed_data,
    input  wire logic                  i_echo_command,
    input  wire logic [SRC_COUNT-1:0]  i_source_enable,
    input  wire logic                  i_init_complete_lock,
    input  wire logic                  i_mismatch_clear,
    // error reply for the current frame
    output logic                       o_err_reply_active,
    output sec_pkg::sec_reply_t        o_err_reply,
    // requests passed on to the register and data logic
    output sec_pkg::sec_req_t          o_req,
    // status
    output logic                       o_spi_error,
    output logic                       o_third_device_status_mismatch
);

    typedef enum logic {
        SEC_IDLE   = 1'b0,
        SEC_ACTIVE = 1'b1
    } sec_state_t;

    sec_state_t       state_reg;
    logic             sclk_reg;
    logic             ss_n_reg;
    logic [5:0]       edge_cnt_reg;
    logic [31:0]      shift_reg;
    logic [7:0]       crc_reg;
    logic             frame_err_reg;
    logic             miso_bad_reg;

    // classify a command nibble
    function automatic sec_pkg::sec_kind_t sec_kind(input logic [3:0] cmd);
        if (cmd[sec_pkg::CMD_SENSOR_BIT]) begin
            sec_kind = sec_pkg::SEC_KIND_SENSOR;
        end else if (cmd == sec_pkg::CMD_REG_READ) begin
            sec_kind = sec_pkg::SEC_KIND_READ;
        end else if (cmd == sec_pkg::CMD_REG_WRITE) begin
            sec_kind = sec_pkg::SEC_KIND_WRITE;
        end else begin
            sec_kind = sec_pkg::SEC_KIND_OTHER;
        end
    endfunction : sec_kind

    // one serial crc step, msb first
    function automatic logic [7:0] sec_crc_step(input logic [7:0] crc, input logic bit_in);
        logic fb;
        fb = crc[7] ^ bit_in;
        sec_crc_step = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    endfunction : sec_crc_step

    // edge detection of the sampled pins
    logic sclk_rise;
    logic ss_fall;
    logic ss_rise;
    assign sclk_rise = i_sclk & ~sclk_reg;
    assign ss_fall   = ss_n_reg & ~i_ss_n;
    assign ss_rise   = ~ss_n_reg & i_ss_n;

    // frame end decode; these levels count only in the cycle where the
    // select release is first seen, and the outputs capture them there,
    // so nothing here needs to be held past the frame end
    logic [3:0]          rx_cmd;
    logic [2:0]          rx_src;
    logic [7:0]          rx_addr;
    sec_pkg::sec_kind_t  rx_kind;
    logic                full_frame;
    logic                count_bad;
    logic                crc_bad;
    logic                src_bad;
    logic                lock_bad;
    logic                clk_bad_end;
    logic                any_err;
    logic                cmd_ok;
    logic                mismatch_now;
    logic                reply_err;
    logic                req_ok;
    logic                bit_take;
    assign rx_cmd      = shift_reg[sec_pkg::CMD_MSB:sec_pkg::CMD_LSB];
    assign rx_src      = shift_reg[sec_pkg::SRC_MSB:sec_pkg::SRC_LSB];
    assign rx_addr     = shift_reg[sec_pkg::ADDR_MSB:sec_pkg::ADDR_LSB];
    assign rx_kind     = sec_kind(rx_cmd);
    assign full_frame  = (edge_cnt_reg == sec_pkg::CNT_FULL);
    assign count_bad   = (edge_cnt_reg != sec_pkg::CNT_ZERO) && !full_frame; // RULE6
    assign clk_bad_end = i_sclk;                                             // RULE5
    assign crc_bad     = full_frame && (crc_reg != shift_reg[7:0]);          // RULE7
    assign src_bad     = full_frame && (rx_kind == sec_pkg::SEC_KIND_SENSOR)
                         && (({29'h0, rx_src} >= 32'(SRC_COUNT))
                             || !i_source_enable[rx_src]);                   // RULE8
    assign lock_bad    = full_frame && i_init_complete_lock
                         && (rx_kind == sec_pkg::SEC_KIND_WRITE)
                         && (rx_addr != sec_pkg::LOCK_WR_ADDR);              // RULE9
    assign any_err     = frame_err_reg | count_bad | clk_bad_end | crc_bad
                         | src_bad | lock_bad;
    assign cmd_ok      = full_frame && !any_err;
    // a full frame with an output mismatch also gets the error reply
    assign reply_err   = any_err || (full_frame && miso_bad_reg);            // RULE15
    // frame end of a clean frame releases a request
    assign req_ok      = ss_rise && cmd_ok;
    // a bit is taken on each serial clock rise inside a frame
    assign bit_take    = (state_reg == SEC_ACTIVE) && sclk_rise;
    assign mismatch_now = bit_take && (i_miso_actual != i_miso_intended);    // RULE11

    // serial clock history for rise detection
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sclk_reg <= 1'b0;
        end else begin
            sclk_reg <= i_sclk;
        end
    end

    // select history; resets to the idle level so reset gives no false edge
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ss_n_reg <= 1'b1;
        end else begin
            ss_n_reg <= i_ss_n;
        end
    end

    // frame state follows the select line
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= SEC_IDLE;
        end else begin
            unique case (state_reg)
                SEC_IDLE: begin
                    if (ss_fall) begin
                        state_reg <= SEC_ACTIVE;
                    end
                end
                SEC_ACTIVE: begin
                    if (ss_rise) begin
                        state_reg <= SEC_IDLE;
                    end
                end
            endcase
        end
    end

    // rising edge counter, saturating so an overlong frame never wraps to 32
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            edge_cnt_reg <= sec_pkg::CNT_ZERO;
        end else if (ss_fall) begin
            edge_cnt_reg <= sec_pkg::CNT_ZERO;
        end else if (bit_take && (edge_cnt_reg != sec_pkg::CNT_MAX)) begin
            edge_cnt_reg <= edge_cnt_reg + sec_pkg::CNT_ONE;                  // RULE6
        end
    end

    // receive shift register, msb first
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            shift_reg <= 32'h0000_0000;
        end else if (bit_take) begin
            shift_reg <= {shift_reg[30:0], i_mosi};
        end
    end

    // running crc over the bits ahead of the crc byte
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            crc_reg <= CRC_SEED;
        end else if (ss_fall) begin
            crc_reg <= CRC_SEED;
        end else if (bit_take && (edge_cnt_reg < sec_pkg::CNT_CRC_END)) begin
            crc_reg <= sec_crc_step(crc_reg, i_mosi);                         // RULE7
        end
    end

    // serial clock level when select is asserted
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            frame_err_reg <= 1'b0;
        end else if (ss_fall) begin
            frame_err_reg <= i_sclk;                                          // RULE5
        end
    end

    // output mismatch seen within the current frame
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            miso_bad_reg <= 1'b0;
        end else if (ss_fall) begin
            miso_bad_reg <= 1'b0;
        end else if (mismatch_now) begin
            miso_bad_reg <= 1'b1;                                             // RULE11
        end
    end

    // sticky mismatch flag; a new mismatch wins over a clear
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_third_device_status_mismatch <= 1'b0;
        end else if (mismatch_now) begin
            o_third_device_status_mismatch <= 1'b1;                           // RULE11
        end else if (i_mismatch_clear) begin
            o_third_device_status_mismatch <= 1'b0;
        end
    end

    // request strobes; reads and sensor requests are held back on mismatch
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_req <= '0;
        end else begin
            o_req.sensor_go <= req_ok && !miso_bad_reg
                               && (rx_kind == sec_pkg::SEC_KIND_SENSOR);      // RULE12
            o_req.read_go   <= req_ok && !miso_bad_reg
                               && (rx_kind == sec_pkg::SEC_KIND_READ);        // RULE14
            o_req.write_go  <= req_ok
                               && (rx_kind == sec_pkg::SEC_KIND_WRITE);       // RULE13
            // the address follows every frame end for the register logic
            if (ss_rise) begin
                o_req.address <= rx_addr;
            end
        end
    end

    // spi error pulse at the end of an offending frame
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_spi_error <= 1'b0;
        end else begin
            o_spi_error <= ss_rise && any_err;                                // RULE10
        end
    end

    // error reply flag, standing for the whole of the next frame
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_err_reply_active <= 1'b0;
        end else if (ss_rise) begin
            o_err_reply_active <= reply_err;                                  // RULE15
        end
    end

    // error reply fields; all zero unless the closed frame was in error
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_err_reply <= '0;
        end else if (ss_rise) begin
            // a cut frame holds no trustworthy command, so it is never echoed
            if (reply_err && full_frame && i_echo_command) begin
                o_err_reply.command_echo <= rx_cmd;                           // RULE1
            end else begin
                o_err_reply.command_echo <= sec_pkg::CMD_ZERO;                // RULE1
            end
            // error codes only stand in for the data of a full sensor request
            if (!reply_err || !full_frame || (rx_kind != sec_pkg::SEC_KIND_SENSOR)) begin
                o_err_reply.sensor_value_field <= sec_pkg::SENSOR_ZERO;       // RULE4
            end else if (i_signed_data) begin
                o_err_reply.sensor_value_field <= sec_pkg::SENSOR_ERR_SGN;    // RULE3
            end else begin
                o_err_reply.sensor_value_field <= sec_pkg::SENSOR_ERR_UNS;    // RULE2
            end
            // status names the spi error whenever the reply is active
            if (reply_err) begin
                o_err_reply.status_field <= sec_pkg::STATUS_SPI_ERR;          // RULE10
            end else begin
                o_err_reply.status_field <= sec_pkg::STATUS_NONE;
            end
        end
    end

endmodule : sec_checker

// *** hdl/sec_pkg.sv ***
// Purpose: shared constants and types for the spi error checker
// Assumes: 32-bit frames, command in the top nibble, crc in the low byte
// Notes:   command codes and field positions are module-wide constants
package sec_pkg;
    // frame geometry
    localparam int unsigned FRAME_BITS   = 32;
    localparam int unsigned CRC_BITS     = 8;
    localparam int unsigned CRC_COVER    = 24;
    localparam int unsigned CNT_W        = 6;
    localparam logic [5:0]  CNT_ZERO     = 6'h00;
    localparam logic [5:0]  CNT_FULL     = 6'h20;
    localparam logic [5:0]  CNT_CRC_END  = 6'h18;
    localparam logic [5:0]  CNT_ONE      = 6'h01;
    localparam logic [5:0]  CNT_MAX      = 6'h3f;
    // field positions in the received frame
    localparam int unsigned CMD_MSB      = 31;
    localparam int unsigned CMD_LSB      = 28;
    localparam int unsigned SRC_MSB      = 27;
    localparam int unsigned SRC_LSB      = 25;
    localparam int unsigned ADDR_MSB     = 23;
    localparam int unsigned ADDR_LSB     = 16;
    // command codes
    localparam logic [3:0]  CMD_REG_READ  = 4'h0;
    localparam logic [3:0]  CMD_REG_WRITE = 4'h1;
    localparam int unsigned CMD_SENSOR_BIT = 3;
    // crc defaults
    localparam logic [7:0]  CRC_POLY     = 8'h2f;
    localparam logic [7:0]  CRC_SEED     = 8'hff;
    // reply codes
    localparam logic [3:0]  STATUS_SPI_ERR  = 4'hf;
    localparam logic [3:0]  STATUS_NONE     = 4'h0;
    localparam logic [11:0] SENSOR_ERR_UNS  = 12'h000;
    localparam logic [11:0] SENSOR_ERR_SGN  = 12'h800;
    localparam logic [11:0] SENSOR_ZERO     = 12'h000;
    localparam logic [3:0]  CMD_ZERO        = 4'h0;
    localparam logic [7:0]  LOCK_WR_ADDR    = 8'h14;

    // kind of command decoded from a frame
    typedef enum logic [1:0] {
        SEC_KIND_READ   = 2'b00,
        SEC_KIND_WRITE  = 2'b01,
        SEC_KIND_SENSOR = 2'b10,
        SEC_KIND_OTHER  = 2'b11
    } sec_kind_t;

    // error reply fields handed to the response builder
    typedef struct packed {
        logic [3:0]  command_echo;
        logic [11:0] sensor_value_field;
        logic [3:0]  status_field;
    } sec_reply_t;

    // one-cycle request strobes issued at frame end
    typedef struct packed {
        logic       sensor_go;
        logic       read_go;
        logic       write_go;
        logic [7:0] address;
    } sec_req_t;
endpackage : sec_pkg
